// [src/pwm_cycle_ctrl.sv]
// pwm cycle length, overflow flag, reload steering and comparator clear
`timescale 1ns/1ps
`include "pwm_cycle_defines.svh"
module pwm_cycle_ctrl #(
   parameter int NUM_CH = 3
) (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire pwm_cycle_pkg::sfr_req_type sfr_req_in,
   output logic [7:0] sfr_rdata_out,
   input wire logic [15:0] counter_in,
   input wire logic comparator_in,
   output logic [NUM_CH-1:0] channel_output_pin_out,
   output logic irq_out
);
   import pwm_cycle_pkg::*;

   logic [7:0] cycle_cfg;
   logic [7:0] next_cycle_cfg;
   logic [7:0] clear_ctrl;
   logic [7:0] next_clear_ctrl;
   logic [7:0] mode [NUM_CH];
   logic [7:0] next_mode [NUM_CH];
   logic [15:0] compare [NUM_CH];
   logic [15:0] next_compare [NUM_CH];
   logic [15:0] reload [NUM_CH];
   logic [15:0] next_reload [NUM_CH];
   logic [15:0] prev_counter;
   logic [7:0] next_rdata;
   logic next_irq;
   logic reload_register_select;
   logic cycle_overflow_irq_enable;
   logic cycle_overflow_flag;
   cycle_length_type cycle_length_select;
   logic cycle_wrap;
   logic wide_wrap;
   logic [10:0] len_mask;
   logic clear_pulse;
   logic cfg_write;
   logic [NUM_CH-1:0] chan_start;
   logic [NUM_CH-1:0] chan_match;
   logic [NUM_CH-1:0] wide_pwm_select;
   logic [NUM_CH-1:0] pwm_enable;

   // low counter bits that make up one narrow cycle
   function automatic logic [10:0] cycle_mask(input cycle_length_type len);
      logic [10:0] m;
      m = 11'h0ff;
      unique case (len)
         LEN_8: m = 11'h0ff;
         LEN_9: m = 11'h1ff;
         LEN_10: m = 11'h3ff;
         LEN_11: m = 11'h7ff;
      endcase
      return m;
   endfunction

   function automatic logic [7:0] chan_addr(input logic [7:0] base, input logic [7:0] step,
                                            input int idx);
      return base + 8'(idx) * step;
   endfunction

   assign reload_register_select = cycle_cfg[`CFG_SEL_BIT];
   assign cycle_overflow_irq_enable = cycle_cfg[`CFG_IRQ_EN_BIT];
   assign cycle_overflow_flag = cycle_cfg[`CFG_FLAG_BIT];
   assign cycle_length_select = cycle_length_type'(cycle_cfg[`CFG_LEN_MSB:`CFG_LEN_LSB]); // [RULE6]
   assign len_mask = cycle_mask(cycle_length_select); // [RULE6]
   assign cfg_write = sfr_req_in.wr && (sfr_req_in.addr == `CYCLE_CFG_ADDR);

   // carry out of the top cycle bit: low bits were all ones and are now zero
   assign cycle_wrap = ((prev_counter[10:0] & len_mask) == len_mask)
                       && ((counter_in[10:0] & len_mask) == 11'h000); // [RULE4]
   assign wide_wrap = (prev_counter == 16'hffff) && (counter_in == 16'h0000);

   always_comb begin
      for (int i = 0; i < NUM_CH; i++) begin
         wide_pwm_select[i] = mode[i][`MODE_WIDE_BIT]; // [RULE11]
         pwm_enable[i] = mode[i][`MODE_PWM_BIT];
         if (wide_pwm_select[i]) begin
            // wide channels run the full counter and ignore the length field
            chan_start[i] = wide_wrap; // [RULE7]
            chan_match[i] = (counter_in == compare[i]); // [RULE11]
         end else begin
            chan_start[i] = cycle_wrap; // [RULE7]
            chan_match[i] = ((counter_in[10:0] & len_mask) == (compare[i][10:0] & len_mask));
         end
      end
   end

   // configuration and clear control registers
   always_comb begin
      next_cycle_cfg = cycle_cfg;
      next_clear_ctrl = clear_ctrl;
      if (cfg_write) begin
         next_cycle_cfg = sfr_req_in.wdata & `CFG_WRITE_MASK; // [RULE8]
      end
      // hardware only ever sets the flag, and a set beats a same-cycle clear
      if (cycle_wrap) begin
         next_cycle_cfg[`CFG_FLAG_BIT] = 1'b1; // [RULE4] [RULE5]
      end
      if (sfr_req_in.wr && (sfr_req_in.addr == `CLEAR_CTRL_ADDR)) begin
         next_clear_ctrl = sfr_req_in.wdata; // [RULE13]
      end
      next_irq = cycle_overflow_flag && cycle_overflow_irq_enable; // [RULE3]
   end

   // mode, compare and reload registers
   always_comb begin
      for (int i = 0; i < NUM_CH; i++) begin
         next_mode[i] = mode[i];
         next_compare[i] = compare[i];
         next_reload[i] = reload[i];
         // reload feeds compare only in 9 to 11-bit narrow pwm
         if (chan_start[i] && !wide_pwm_select[i] && cycle_length_select != LEN_8) begin
            next_compare[i] = reload[i]; // [RULE2] [RULE12]
         end
         if (sfr_req_in.wr) begin
            if (sfr_req_in.addr == chan_addr(`MODE_ADDR0, `MODE_ADDR_STEP, i)) begin
               next_mode[i] = sfr_req_in.wdata;
            end
            if (sfr_req_in.addr == chan_addr(`CMP_LO_ADDR0, `CMP_ADDR_STEP, i)) begin
               if (reload_register_select) begin
                  next_reload[i][7:0] = sfr_req_in.wdata; // [RULE1]
               end else begin
                  next_compare[i][7:0] = sfr_req_in.wdata; // [RULE1]
               end
            end
            if (sfr_req_in.addr == chan_addr(`CMP_HI_ADDR0, `CMP_ADDR_STEP, i)) begin
               if (reload_register_select) begin
                  next_reload[i][15:8] = sfr_req_in.wdata; // [RULE1]
               end else begin
                  next_compare[i][15:8] = sfr_req_in.wdata; // [RULE1]
               end
            end
         end
      end
   end

   // read data, unmapped addresses return zero
   always_comb begin
      next_rdata = sfr_rdata_out;
      if (sfr_req_in.rd) begin
         next_rdata = 8'h00;
         if (sfr_req_in.addr == `CYCLE_CFG_ADDR) begin
            next_rdata = cycle_cfg & `CFG_WRITE_MASK; // [RULE8]
         end
         if (sfr_req_in.addr == `CLEAR_CTRL_ADDR) begin
            next_rdata = clear_ctrl;
         end
         for (int i = 0; i < NUM_CH; i++) begin
            if (sfr_req_in.addr == chan_addr(`MODE_ADDR0, `MODE_ADDR_STEP, i)) begin
               next_rdata = mode[i];
            end
            if (sfr_req_in.addr == chan_addr(`CMP_LO_ADDR0, `CMP_ADDR_STEP, i)) begin
               next_rdata = reload_register_select ? reload[i][7:0] : compare[i][7:0]; // [RULE1]
            end
            if (sfr_req_in.addr == chan_addr(`CMP_HI_ADDR0, `CMP_ADDR_STEP, i)) begin
               next_rdata = reload_register_select ? reload[i][15:8] : compare[i][15:8]; // [RULE1]
            end
         end
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         cycle_cfg <= `CFG_RESET;
         clear_ctrl <= `CLR_RESET;
         prev_counter <= 16'h0000;
         sfr_rdata_out <= 8'h00;
         irq_out <= 1'b0;
         for (int i = 0; i < NUM_CH; i++) begin
            mode[i] <= `MODE_RESET;
            compare[i] <= `CMP_RESET;
            reload[i] <= `CMP_RESET;
         end
      end else begin
         cycle_cfg <= next_cycle_cfg;
         clear_ctrl <= next_clear_ctrl;
         prev_counter <= counter_in;
         sfr_rdata_out <= next_rdata;
         irq_out <= next_irq;
         for (int i = 0; i < NUM_CH; i++) begin
            mode[i] <= next_mode[i];
            compare[i] <= next_compare[i];
            reload[i] <= next_reload[i];
         end
      end
   end

   comparator_edge u_edge (
      .clk_in(clk_in),
      .rstn_in(rstn_in),
      .comparator_in(comparator_in),
      .polarity_in(clear_ctrl[`CLR_POL_BIT]), // [RULE9]
      .clear_pulse_out(clear_pulse)
   );

   for (genvar g = 0; g < NUM_CH; g++) begin : g_chan
      pwm_channel u_chan (
         .clk_in(clk_in),
         .rstn_in(rstn_in),
         .pwm_enable_in(pwm_enable[g]),
         .start_in(chan_start[g]),
         .match_in(chan_match[g]),
         .clear_enable_in(clear_ctrl[g]), // [RULE10]
         .clear_pulse_in(clear_pulse),
         .level_out(channel_output_pin_out[g])
      );
   end

   property p_sel_compare;
      @(posedge clk_in) disable iff (!rstn_in)
      (sfr_req_in.wr && sfr_req_in.addr == `CMP_LO_ADDR0 && !reload_register_select
       && !chan_start[0])
      |=> (compare[0][7:0] == $past(sfr_req_in.wdata)) && $stable(reload[0]);
   endproperty
   a_sel_compare: assert property (p_sel_compare) else $error("select low missed compare"); // [RULE1]

   property p_sel_reload;
      @(posedge clk_in) disable iff (!rstn_in)
      (sfr_req_in.wr && sfr_req_in.addr == `CMP_LO_ADDR0 && reload_register_select)
      |=> reload[0][7:0] == $past(sfr_req_in.wdata);
   endproperty
   a_sel_reload: assert property (p_sel_reload) else $error("select high missed reload"); // [RULE1]

   property p_no_reload_8bit;
      @(posedge clk_in) disable iff (!rstn_in)
      (cycle_length_select == LEN_8 && !sfr_req_in.wr) |=> $stable(compare[0]);
   endproperty
   a_no_reload_8bit: assert property (p_no_reload_8bit) else $error("8-bit reload acted"); // [RULE2]

   property p_irq;
      @(posedge clk_in) disable iff (!rstn_in)
      (cycle_overflow_flag && cycle_overflow_irq_enable) |=> irq_out;
   endproperty
   a_irq: assert property (p_irq) else $error("flag did not raise request"); // [RULE3]

   property p_irq_masked;
      @(posedge clk_in) disable iff (!rstn_in)
      !cycle_overflow_irq_enable |=> !irq_out;
   endproperty
   a_irq_masked: assert property (p_irq_masked) else $error("masked flag raised request"); // [RULE3]

   property p_flag_set;
      @(posedge clk_in) disable iff (!rstn_in)
      (cycle_length_select == LEN_11 && prev_counter[10:0] == 11'h7ff
       && counter_in[10:0] == 11'h000) |=> cycle_overflow_flag;
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("11-bit overflow not flagged"); // [RULE4]

   property p_flag_sticky;
      @(posedge clk_in) disable iff (!rstn_in)
      (cycle_overflow_flag && !cfg_write) |=> cycle_overflow_flag;
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) else $error("hardware cleared flag"); // [RULE5]

   property p_unused_zero;
      @(posedge clk_in) disable iff (!rstn_in)
      (sfr_req_in.rd && sfr_req_in.addr == `CYCLE_CFG_ADDR) |=> sfr_rdata_out[4:2] == 3'h0;
   endproperty
   a_unused_zero: assert property (p_unused_zero) else $error("unused bits read nonzero"); // [RULE8]

   property p_reload_copy;
      @(posedge clk_in) disable iff (!rstn_in)
      (cycle_wrap && !wide_pwm_select[0] && cycle_length_select != LEN_8 && !sfr_req_in.wr)
      |=> compare[0] == $past(reload[0]);
   endproperty
   a_reload_copy: assert property (p_reload_copy) else $error("reload not copied"); // [RULE12]
endmodule

// [pkg/pwm_cycle_defines.svh]
// register offsets, field positions and reset values for the pwm cycle block
// How it works
// RULE1: select bit 7 low reaches compare registers, high reaches reload registers.
// RULE2: reload values act only in 9, 10 and 11-bit cycle lengths.
// RULE3: overflow interrupt enable bit 6 gates the overflow flag onto the request.
// RULE4: overflow flag sets on carry out of counter bit 7, 8, 9 or 10.
// RULE5: overflow flag bit 5 set by hardware or software; only software clears it.
// RULE6: cycle length field 00/01/10/11 gives 8/9/10/11-bit cycles.
// RULE7: cycle length applies to narrow pwm channels; wide channels ignore it.
// RULE8: configuration bits 4 to 2 read zero and ignore writes.
// RULE9: polarity bit 7 low clears on falling comparator, high on rising.
// RULE10: clear enable bits 0, 1, 2 select channels 0, 1, 2 for clearing.
// RULE11: mode bit 7 selects 16-bit pwm when set, 8 to 11-bit when clear.
// RULE12: in 9 to 11-bit mode reload copies into compare at each cycle overflow.
// RULE13: software writes zero to clear control bits 6 to 3.
`ifndef PWM_CYCLE_DEFINES_SVH
`define PWM_CYCLE_DEFINES_SVH

`define CYCLE_CFG_ADDR 8'hf7
`define CLEAR_CTRL_ADDR 8'hce
`define MODE_ADDR0 8'hda
`define MODE_ADDR_STEP 8'h01
`define CMP_LO_ADDR0 8'he9
`define CMP_HI_ADDR0 8'hea
`define CMP_ADDR_STEP 8'h02

`define CFG_SEL_BIT 7
`define CFG_IRQ_EN_BIT 6
`define CFG_FLAG_BIT 5
`define CFG_LEN_MSB 1
`define CFG_LEN_LSB 0
`define CFG_RESET 8'h00
`define CFG_WRITE_MASK 8'he3

`define CLR_POL_BIT 7
`define CLR_RESET 8'h00

`define MODE_WIDE_BIT 7
`define MODE_PWM_BIT 1
`define MODE_RESET 8'h00
`define CMP_RESET 16'h0000

`endif

// [pkg/pwm_cycle_pkg.sv]
// types shared by the pwm cycle block
package pwm_cycle_pkg;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } sfr_req_type;

   typedef enum logic [1:0] {
      LEN_8,
      LEN_9,
      LEN_10,
      LEN_11
   } cycle_length_type;

endpackage

// [src/comparator_edge.sv]
// comparator synchroniser and polarity-selected clearing edge
`timescale 1ns/1ps
module comparator_edge (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic comparator_in,
   input wire logic polarity_in,
   output logic clear_pulse_out
);
   logic sync_a;
   logic sync_b;
   logic last_b;
   logic next_pulse;

   always_comb begin
      // falling edge when polarity low, rising edge when high
      if (polarity_in) begin
         next_pulse = sync_b & ~last_b; // [RULE9]
      end else begin
         next_pulse = ~sync_b & last_b; // [RULE9]
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         sync_a <= 1'b0;
         sync_b <= 1'b0;
         last_b <= 1'b0;
         clear_pulse_out <= 1'b0;
      end else begin
         sync_a <= comparator_in;
         sync_b <= sync_a;
         last_b <= sync_b;
         clear_pulse_out <= next_pulse;
      end
   end

   property p_pol_edge;
      @(posedge clk_in) disable iff (!rstn_in)
      (!polarity_in && $fell(sync_b)) |=> clear_pulse_out;
   endproperty
   a_pol_edge: assert property (p_pol_edge) else $error("falling edge gave no clear"); // [RULE9]
endmodule

// [src/pwm_channel.sv]
// one channel output level: set at cycle start, cleared by match or comparator
`timescale 1ns/1ps
module pwm_channel (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic pwm_enable_in,
   input wire logic start_in,
   input wire logic match_in,
   input wire logic clear_enable_in,
   input wire logic clear_pulse_in,
   output logic level_out
);
   logic next_level;

   always_comb begin
      next_level = level_out;
      if (!pwm_enable_in) begin
         next_level = 1'b0;
      end else if (clear_enable_in && clear_pulse_in) begin
         next_level = 1'b0; // [RULE10]
      end else if (match_in) begin
         next_level = 1'b0;
      end else if (start_in) begin
         next_level = 1'b1;
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         level_out <= 1'b0;
      end else begin
         level_out <= next_level;
      end
   end

   property p_clear;
      @(posedge clk_in) disable iff (!rstn_in)
      (clear_enable_in && clear_pulse_in) |=> !level_out;
   endproperty
   a_clear: assert property (p_clear) else $error("enabled channel not cleared"); // [RULE10]

   property p_no_clear;
      @(posedge clk_in) disable iff (!rstn_in)
      (!clear_enable_in && pwm_enable_in && start_in && !match_in) |=> level_out;
   endproperty
   a_no_clear: assert property (p_no_clear) else $error("disabled channel was cleared"); // [RULE10]
endmodule

// [verif/pwm_far_side.sv]
// far-side model: main counter and comparator result
`timescale 1ns/1ps
module pwm_far_side (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic run_in,
   input wire logic load_in,
   input wire logic [15:0] load_value_in,
   input wire logic level_in,
   output logic [15:0] counter_out,
   output logic comparator_out
);
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         counter_out <= 16'h0000;
      end else if (load_in) begin
         counter_out <= load_value_in;
      end else begin
         counter_out <= counter_out + {15'h0000, run_in};
      end
   end
   // analog result moves off the clock grid
   assign #3 comparator_out = level_in;
endmodule

// [verif/tb.sv]
// self-checking bench for the pwm cycle block
`timescale 1ns/1ps
module tb;
   import pwm_cycle_pkg::*;
   logic clk_in = 1'b0;
   logic rstn_in = 1'b0;
   sfr_req_type req = '0;
   logic [7:0] sfr_rdata_out;
   logic [15:0] counter;
   logic comparator;
   logic [2:0] pins;
   logic irq_out;
   logic run = 1'b0;
   logic load = 1'b0;
   logic [15:0] load_value = 16'h0000;
   logic level = 1'b0;
   int fails = 0;
   int check_count = 0;
   int cmp[3];
   int rld[3];
   logic [31:0] seed = 32'h44e5;

   pwm_cycle_ctrl #(.NUM_CH(3)) uut (.clk_in(clk_in), .rstn_in(rstn_in), .sfr_req_in(req),
      .sfr_rdata_out(sfr_rdata_out), .counter_in(counter), .comparator_in(comparator),
      .channel_output_pin_out(pins), .irq_out(irq_out));
   pwm_far_side far (.clk_in(clk_in), .rstn_in(rstn_in), .run_in(run), .load_in(load),
      .load_value_in(load_value), .level_in(level), .counter_out(counter),
      .comparator_out(comparator));

   initial begin
      forever #12.5 clk_in = ~clk_in;
   end

   function automatic logic [31:0] xorshift(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      x = x ^ (x << 5);
      return x;
   endfunction

   task automatic conclude();
      if (fails == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_in);
      req <= '0;
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk_in);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk_in);
      req <= '0;
      #1;
      check({8'h00, sfr_rdata_out}, {8'h00, exp});
   endtask

   task automatic cycles(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask

   task automatic load_counter(input logic [15:0] v);
      @(posedge clk_in);
      load <= 1'b1;
      load_value <= v;
      @(posedge clk_in);
      load <= 1'b0;
   endtask

   task automatic set_pair(input int ch, input int v, input bit reload);
      wr(8'he9 + 8'(2 * ch), 8'(v));
      wr(8'hea + 8'(2 * ch), 8'(v >> 8));
      if (reload) begin
         rld[ch] = v;
      end else begin
         cmp[ch] = v;
      end
   endtask

   initial begin
      repeat (100000) @(posedge clk_in);
      fails++;
      conclude();
   end

   initial begin
      int n;
      for (int i = 0; i < 3; i++) begin
         cmp[i] = 0;
         rld[i] = 0;
      end
      repeat (20) @(posedge clk_in);
      rstn_in <= 1'b1;
      rdchk(8'hf7, 8'h00);
      rdchk(8'hce, 8'h00);
      rdchk(8'h00, 8'h00);
      wr(8'hf7, 8'hff);
      rdchk(8'hf7, 8'he3);
      check(irq_out, 1'b1);
      wr(8'hf7, 8'h23);
      rdchk(8'hf7, 8'h23);
      check(irq_out, 1'b0);
      wr(8'hce, 8'h87);
      rdchk(8'hce, 8'h87);
      @(posedge clk_in);
      run <= 1'b1;
      for (int len = 0; len < 4; len++) begin
         n = 8 + len;
         seed = xorshift(seed);
         load_counter(16'(seed << n) | 16'((1 << (n - 1)) - 4));
         wr(8'hf7, 8'h40 | 8'(len));
         cycles(6);
         rdchk(8'hf7, 8'h40 | 8'(len));
         check(irq_out, 1'b0);
         seed = xorshift(seed);
         load_counter(16'(seed << n) | 16'((1 << n) - 4));
         cycles(8);
         rdchk(8'hf7, 8'h60 | 8'(len));
         check(irq_out, 1'b1);
      end
      wr(8'hf7, 8'h00);
      wr(8'hda, 8'h02);
      wr(8'hdb, 8'h02);
      wr(8'hdc, 8'h82);
      set_pair(0, 16'h00f0, 1'b0);
      set_pair(1, 16'h00f0, 1'b0);
      set_pair(2, 16'h0110, 1'b0);
      wr(8'hce, 8'h81);
      load_counter(16'hfffc);
      cycles(36);
      check(pins, 3'b111);
      @(posedge clk_in);
      level <= 1'b1;
      cycles(6);
      check(pins, 3'b110);
      wr(8'hce, 8'h02);
      @(posedge clk_in);
      level <= 1'b0;
      cycles(6);
      check(pins, 3'b100);
      load_counter(16'h0000);
      wr(8'hf7, 8'h81);
      set_pair(0, 16'h0155, 1'b1);
      rdchk(8'he9, 8'(rld[0]));
      wr(8'hf7, 8'h01);
      rdchk(8'he9, 8'(cmp[0]));
      load_counter(16'h01fc);
      cycles(8);
      cmp[0] = rld[0];
      cmp[1] = rld[1];
      rdchk(8'he9, 8'(cmp[0]));
      rdchk(8'hea, 8'(cmp[0] >> 8));
      rdchk(8'heb, 8'(cmp[1]));
      wr(8'hf7, 8'h80);
      set_pair(1, 16'h0133, 1'b1);
      load_counter(16'h00fc);
      cycles(8);
      wr(8'hf7, 8'h00);
      rdchk(8'heb, 8'(cmp[1]));
      rdchk(8'hed, 8'(cmp[2]));
      conclude();
   end
endmodule
